// ===== dv/dsf_control_properties.sv
/*
 * dsf_control_properties: port-level checks of dsf_control.
 * Assumes only the watched ports; the control word is shadowed from apb writes.
 */
`timescale 1ns/1ps
module dsf_control_properties #(
	parameter int SLEEP_CYC = dsf_pkg::SLEEP_ENTRY_CYC
) (
	input wire logic                core_clk,
	input wire logic                rst,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic                sleep_reset_pin_n,
	input wire logic                serial_strobe_n,
	input wire dsf_pkg::dsf_fault_s fault_in,
	input wire logic [1:0]          short_phase,
	input wire logic                fault_indicator_pin_oe,
	input wire logic [1:0]          bridge_enable,
	input wire logic                regulator_enable,
	input wire logic                pwm_period_start,
	input wire logic [15:0]         pwm_period_cyc
);
	localparam int SL_LO = SLEEP_CYC - 6;
	localparam int SL_HI = SLEEP_CYC;
	logic [17:0] ctrl_q;
	logic        shown;
	int          low_cnt;
	logic        ctrl_wr;

	// ------------
	// helper state
	// ------------
	assign ctrl_wr = psel && penable && pwrite && paddr == dsf_pkg::ADDR_CTRL;
	always_ff @(posedge core_clk) begin
		if (rst) ctrl_q <= '0;
		else if (ctrl_wr) ctrl_q <= pwdata[17:0];
	end
	// a sleep outcome owns the pin until software rewrites the control word
	always_ff @(posedge core_clk) begin
		if (rst) shown <= 1'b0;
		else if (!regulator_enable || !sleep_reset_pin_n) shown <= 1'b1;
		else if (ctrl_wr) shown <= 1'b0;
	end
	always_ff @(posedge core_clk) begin
		if (rst || sleep_reset_pin_n) low_cnt <= 0;
		else if (low_cnt < 1000) low_cnt <= low_cnt + 1;
	end

	// ------------
	// checks
	// ------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence bit_entry_s;
		$rose(serial_strobe_n) && ctrl_q[17] && bridge_enable == 2'b11;
	endsequence
	sequence asleep_s;
		!regulator_enable && bridge_enable == 2'b00;
	endsequence

	period_floor_a: assert property (pwm_period_cyc >= 16'(dsf_pkg::MIN_PERIOD_CYC))
		else $error("period below floor");
	period_wrap_a: assert property ($changed(pwm_period_cyc) && !$past(pwm_period_start)
		|-> ##[0:1] pwm_period_start) else $error("period changed mid period");
	sleep_off_a: assert property (!regulator_enable |-> bridge_enable == 2'b00)
		else $error("bridge on while regulators off");
	pin_sleep_a: assert property (low_cnt == SLEEP_CYC + 4
		|-> asleep_s and !fault_indicator_pin_oe) else $error("pin sleep not reached");
	pin_wake_a: assert property ($rose(sleep_reset_pin_n) && !regulator_enable
		|-> ##[1:40] regulator_enable) else $error("no wake after pin rise");
	bit_sleep_a: assert property (bit_entry_s |=> regulator_enable[*4]
		##[SL_LO:SL_HI] asleep_s) else $error("bit sleep timing wrong");
	short_latch_a: assert property (fault_in.bridge_short && short_phase == 2'b01
		|-> ##2 (!bridge_enable[0])[*4]) else $error("short not latched");
	static_off_a: assert property (|{fault_in.supply_overvolt, fault_in.supply_undervolt,
		fault_in.cp_undervolt, fault_in.overtemp} |-> ##[1:2] bridge_enable == 2'b00)
		else $error("static fault left outputs on");
	general_ind_a: assert property (!shown && ctrl_q[16:14] == 3'h0 && |fault_in[5:0]
		|-> ##[1:2] fault_indicator_pin_oe) else $error("general flag not low");
	supply_ind_a: assert property (!shown && ctrl_q[16:14] == 3'h1 && |fault_in[2:0]
		|-> ##[1:2] fault_indicator_pin_oe) else $error("supply flag not low");
endmodule

bind dsf_control dsf_control_properties #(.SLEEP_CYC(SLEEP_CYC)) u_dsf_control_properties (
	.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .sleep_reset_pin_n,
	.serial_strobe_n, .fault_in, .short_phase, .fault_indicator_pin_oe, .bridge_enable,
	.regulator_enable, .pwm_period_start, .pwm_period_cyc);

// ===== dv/dsf_host.sv
/*
 * dsf_host: host controller model driving the sleep pin and serial strobe.
 * Assumes the caller sequences frames; pins change just after core_clk rises.
 */
`timescale 1ns/1ps
module dsf_host #(
	parameter int IR_CYC = 4
) (
	input wire logic core_clk,
	output logic     sleep_reset_pin_n,
	output logic     serial_strobe_n
);
	// the indicator is never read here, so entry and wake windows are safe
	initial begin
		sleep_reset_pin_n = 1'b1;
		serial_strobe_n = 1'b1;
	end
	// pin is raised before any clearing write is issued
	task automatic pin(input logic v);
		@(posedge core_clk);
		sleep_reset_pin_n <= v;
	endtask
	// after a strobe fall stay quiet while the interface powers up
	task automatic strobe(input logic v);
		@(posedge core_clk);
		serial_strobe_n <= v;
		if (!v) repeat (IR_CYC) @(posedge core_clk);
	endtask
endmodule

// ===== dv/tb.sv
/*
 * tb: self-checking bench for dsf_control with a host model on the sleep pins.
 * Assumes shortened dwell, sleep, wake and divider parameters set below.
 */
`timescale 1ns/1ps
module tb;
	localparam int SLP = 10;
	localparam int WK = 10;
	localparam int DW = 3700;
	localparam logic [14:0] ROWS [10] = '{{3'h1, 8'h04, 4'h1}, {3'h1, 8'h08, 4'h0},
		{3'h3, 8'h00, 4'h8}, {3'h3, 8'h00, 4'h1}, {3'h4, 8'h00, 4'h4}, {3'h4, 8'h00, 4'h1},
		{3'h5, 8'h00, 4'h3}, {3'h5, 8'h00, 4'h0}, {3'h7, 8'h20, 4'h1}, {3'h2, 8'h80, 4'h1}};
	logic core_clk = 1'b0, rst = 1'b1, psel, penable, pwrite;
	logic [7:0]          paddr;
	logic [31:0]         pwdata, prdata, rd;
	logic                pready, pslverr, err, fault_indicator_pin_o, fault_indicator_pin_oe;
	logic                regulator_enable, pwm_period_start, sleep_reset_pin_n, serial_strobe_n;
	logic [1:0]          bridge_enable, short_phase;
	logic [15:0]         pwm_period_cyc;
	dsf_pkg::dsf_fault_s fault_in;
	logic                phase_a_pwm, step_pulse, sequence_active_flag;
	int                  n_errors = 0, tests_run = 0, cyc = 0;

	always #5 core_clk = ~core_clk;
	dsf_control #(.DWELL_1_CYC(DW), .DWELL_2_CYC(2 * DW), .DWELL_5_CYC(5 * DW),
		.DWELL_10_CYC(10 * DW), .SLEEP_CYC(SLP), .WAKE_CYC(WK), .IND_HALF(8)) u_dsf_control (
		.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .sleep_reset_pin_n, .serial_strobe_n, .fault_in, .short_phase, .phase_a_pwm,
		.step_pulse, .sequence_active_flag, .fault_indicator_pin_o, .fault_indicator_pin_oe,
		.bridge_enable, .regulator_enable, .pwm_period_start, .pwm_period_cyc);
	dsf_host #(.IR_CYC(4)) u_dsf_host (.core_clk, .sleep_reset_pin_n, .serial_strobe_n);

	// ------------
	// shared tasks
	// ------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic summarize();
		if (n_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wake(input logic [31:0] d);
		u_dsf_host.strobe(1'b0);
		apb(1'b1, dsf_pkg::ADDR_CTRL, d);
		u_dsf_host.strobe(1'b1);
		repeat (WK + SLP + 8) @(posedge core_clk);
	endtask
	task automatic at_start(input int n);
		repeat (n) @(posedge core_clk iff pwm_period_start === 1'b1);
		@(posedge core_clk);
	endtask

	// ------------
	// scenarios
	// ------------
	task automatic t_regs();
		apb(1'b0, dsf_pkg::ADDR_CTRL, '0);
		chk(rd, dsf_pkg::CTRL_RESET);
		apb(1'b0, 8'h0c, '0);
		chk({err, rd}, {1'b1, 32'h0});
	endtask
	task automatic t_pin_sleep();
		u_dsf_host.pin(1'b0);
		repeat (SLP + 6) @(posedge core_clk);
		chk({fault_indicator_pin_o, regulator_enable, bridge_enable}, 4'h0);
		chk(fault_indicator_pin_oe, 1'b0);
		u_dsf_host.pin(1'b1);
		repeat (WK + 8) @(posedge core_clk);
		chk(bridge_enable, 2'h3);
		u_dsf_host.pin(1'b0);
		repeat (3) @(posedge core_clk);
		u_dsf_host.pin(1'b1);
		repeat (SLP + 6) @(posedge core_clk);
		chk({regulator_enable, fault_indicator_pin_oe}, 2'h3);
	endtask
	task automatic t_bit_sleep();
		apb(1'b1, dsf_pkg::ADDR_CTRL, 32'h0002_0000);
		u_dsf_host.strobe(1'b0);
		u_dsf_host.strobe(1'b1);
		repeat (SLP + 6) @(posedge core_clk);
		chk({regulator_enable, fault_indicator_pin_oe}, 2'h0);
		wake(32'h0002_0000);
		chk({regulator_enable, fault_indicator_pin_oe}, 2'h1);
		wake(32'h0);
		chk({regulator_enable, bridge_enable, fault_indicator_pin_oe}, 4'he);
	endtask
	task automatic t_dither();
		int k;
		int lvl;
		int v;
		logic [15:0] prev;
		apb(1'b1, dsf_pkg::ADDR_CTRL, 32'h0000_00f4);
		at_start(2);
		chk(pwm_period_cyc, 16'(dsf_pkg::BASE_PERIOD_CYC + 20 * dsf_pkg::BASE_STEP_CYC));
		apb(1'b1, dsf_pkg::ADDR_CTRL, 32'h0000_00e0);
		at_start(2);
		chk(pwm_period_cyc, 16'(dsf_pkg::BASE_PERIOD_CYC));
		apb(1'b1, dsf_pkg::ADDR_CTRL, 32'h0000_30e0);
		prev = '1;
		k = 0;
		while (k < 14) begin
			at_start(1);
			if (pwm_period_cyc !== prev) begin
				lvl = k <= 12 ? k : 24 - k;
				v = dsf_pkg::BASE_PERIOD_CYC - lvl * 8 * dsf_pkg::DITHER_UNIT_CYC;
				v = v < dsf_pkg::MIN_PERIOD_CYC ? dsf_pkg::MIN_PERIOD_CYC : v;
				chk(pwm_period_cyc, 16'(v));
				prev = pwm_period_cyc;
				k++;
			end
		end
		apb(1'b1, dsf_pkg::ADDR_CTRL, 32'h0);
	endtask
	task automatic t_faults();
		for (int i = 0; i < 6; i++) begin
			fault_in <= dsf_pkg::dsf_fault_s'(8'h01 << i);
			repeat (3) @(posedge core_clk);
			chk({fault_indicator_pin_oe, bridge_enable}, (i == 3 || i == 5) ? 3'h7 : 3'h4);
			fault_in <= '0;
			repeat (3) @(posedge core_clk);
			chk(fault_indicator_pin_oe, 1'b0);
			apb(1'b0, dsf_pkg::ADDR_STATUS, '0);
			chk(rd, 32'h1 << i);
			apb(1'b1, dsf_pkg::ADDR_STATUS, '0);
			apb(1'b0, dsf_pkg::ADDR_STATUS, '0);
			chk(rd, 32'h0);
		end
		fault_in.overtemp <= 1'b1;
		apb(1'b1, dsf_pkg::ADDR_STATUS, '0);
		apb(1'b0, dsf_pkg::ADDR_STATUS, '0);
		chk(rd, 32'h10);
		fault_in <= '0;
		short_phase <= 2'h1;
		fault_in.bridge_short <= 1'b1;
		@(posedge core_clk);
		fault_in <= '0;
		repeat (3) @(posedge core_clk);
		chk({fault_indicator_pin_oe, bridge_enable}, 3'h6);
		fault_in.bridge_open <= 1'b1;
		apb(1'b1, dsf_pkg::ADDR_STATUS, '0);
		fault_in <= '0;
		repeat (3) @(posedge core_clk);
		chk({fault_indicator_pin_oe, bridge_enable}, 3'h7);
		apb(1'b0, dsf_pkg::ADDR_STATUS, '0);
		chk(rd, 32'h80);
		apb(1'b1, dsf_pkg::ADDR_STATUS, '0);
		repeat (3) @(posedge core_clk);
		chk(fault_indicator_pin_oe, 1'b0);
	endtask
	task automatic t_ind();
		int n;
		logic v;
		foreach (ROWS[i]) begin
			{phase_a_pwm, step_pulse, sequence_active_flag} <= ROWS[i][3:1];
			apb(1'b1, dsf_pkg::ADDR_CTRL, 32'(ROWS[i][14:12]) << 14);
			fault_in <= dsf_pkg::dsf_fault_s'(ROWS[i][11:4]);
			repeat (3) @(posedge core_clk);
			chk(fault_indicator_pin_oe, ROWS[i][0]);
			fault_in <= '0;
		end
		apb(1'b1, dsf_pkg::ADDR_STATUS, '0);
		apb(1'b1, dsf_pkg::ADDR_CTRL, 32'h0001_8000);
		v = fault_indicator_pin_oe;
		while (fault_indicator_pin_oe === v) @(posedge core_clk);
		v = fault_indicator_pin_oe;
		n = 0;
		while (fault_indicator_pin_oe === v) begin
			@(posedge core_clk);
			n++;
		end
		chk(n, 8);
	endtask

	initial begin
		{psel, penable, pwrite, paddr, pwdata, short_phase, fault_in,
			phase_a_pwm, step_pulse, sequence_active_flag} <= '0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		t_regs();
		t_pin_sleep();
		t_bit_sleep();
		t_dither();
		t_faults();
		t_ind();
		summarize();
	end
	// dither sweep dominates the run; the ceiling leaves a modest margin
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 95000) begin
			n_errors++;
			summarize();
		end
	end
endmodule

// ===== hw/dsf_control.sv
/*
 * dsf_control: pwm period dither, sleep entry and exit, fault states with
 * sticky status bits and the open-drain fault indicator.
 * Assumes pins synchronous to core_clk, apb slave with no wait states,
 * and an analog front end that reports fault conditions as levels.
 */
// Our own choices: the APB slave port and the placing of the registers.
// Notes on behaviour
// (R1) period shortens step by step, then lengthens back, repeating a triangle
// (R2) dither step is 0.2 us plus 0.2 us times step code
// (R3) each dithered period holds for 1, 2, 5 or 10 ms dwell
// (R4) step count sets steps per half; zero switches dither off
// (R5) period never goes below 18 us while dither demands shorter
// (R6) sleep by pin low for entry time or by sleep request bit
// (R7) bit-driven sleep starts at strobe rise, completes one entry time later
// (R8) normal only with pin high and request bit clear
// (R9) sleep disables bridges and switches regulators off
// (R10) indicator shows sleep attempt outcome, high success, low failure
// (R11) host ignores indicator during entry and wake windows
// (R12) pin-entered sleep ends on next pin rising edge
// (R13) bit-entered sleep starts waking on first strobe falling edge
// (R14) waking transfer must clear request bit, else back to sleep
// (R15) host waits interface ready time before first serial clock
// (R16) host raises pin before clearing request bit after mixed entry
// (R17) bridge short and open latch; short disables, open only flags
// (R18) static faults live with condition; supply and overtemp disable outputs
// (R19) status bits stay set until their register is reset
// (R20) static fault still present after reset sets its bit again
// (R21) indicator defaults to general fault flag, low on any fault
// (R22) indicator selectable: supply, open load, pwm, step, activity, divided clock
// (R23) supply error low on any supply or charge pump fault
// (R24) base period is 36 us plus 0.8 us per code
// (R25) new dithered period applies only at next period start
// (R26) dwell timed in core clocks, restarting at every step change
`timescale 1ns/1ps

module dsf_control #(
	parameter int DWELL_1_CYC   = dsf_pkg::DWELL_1_MS * dsf_pkg::MS_CYC,
	parameter int DWELL_2_CYC   = dsf_pkg::DWELL_2_MS * dsf_pkg::MS_CYC,
	parameter int DWELL_5_CYC   = dsf_pkg::DWELL_5_MS * dsf_pkg::MS_CYC,
	parameter int DWELL_10_CYC  = dsf_pkg::DWELL_10_MS * dsf_pkg::MS_CYC,
	parameter int SLEEP_CYC     = dsf_pkg::SLEEP_ENTRY_CYC,
	parameter int WAKE_CYC      = dsf_pkg::WAKE_TIME_CYC,
	parameter int IND_HALF      = dsf_pkg::IND_HALF_CYC
) (
	input  wire logic               core_clk,
	input  wire logic               rst,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	input  wire logic               sleep_reset_pin_n,
	input  wire logic               serial_strobe_n,
	input  wire dsf_pkg::dsf_fault_s fault_in,
	input  wire logic [1:0]         short_phase,
	input  wire logic               phase_a_pwm,
	input  wire logic               step_pulse,
	input  wire logic               sequence_active_flag,
	output logic                    fault_indicator_pin_o,
	output logic                    fault_indicator_pin_oe,
	output logic [1:0]              bridge_enable,
	output logic                    regulator_enable,
	output logic                    pwm_period_start,
	output logic [15:0]             pwm_period_cyc
);

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	dsf_pkg::dsf_ctrl_s ctrl;
	dsf_pkg::dsf_fault_s status;
	logic access;
	logic wr_ctrl;
	logic wr_status;
	logic mapped;

	assign access    = psel && penable;
	assign mapped    = paddr == dsf_pkg::ADDR_CTRL || paddr == dsf_pkg::ADDR_STATUS
		|| paddr == dsf_pkg::ADDR_STATE;
	assign wr_ctrl   = access && pwrite && paddr == dsf_pkg::ADDR_CTRL;
	assign wr_status = access && pwrite && paddr == dsf_pkg::ADDR_STATUS;
	assign pready    = 1'b1;
	assign pslverr   = access && !mapped;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ctrl <= dsf_pkg::dsf_ctrl_s'(dsf_pkg::CTRL_RESET[$bits(dsf_pkg::dsf_ctrl_s)-1:0]);
		end else if (wr_ctrl) begin
			ctrl <= dsf_pkg::dsf_ctrl_s'(pwdata[$bits(dsf_pkg::dsf_ctrl_s)-1:0]);
		end
	end

	// ----------------------------------------------------------------
	// sleep control
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SLP_NORMAL, SLP_ENTER_PIN, SLP_ENTER_BIT, SLP_ASLEEP_PIN,
		SLP_ASLEEP_BIT, SLP_WAKE_XFER, SLP_WAKING
	} dsf_sleep_e;

	dsf_sleep_e sleep_state;
	logic [31:0] sleep_cnt;
	logic pin_q;
	logic strobe_q;
	logic strobe_rise;
	logic strobe_fall;
	logic pin_rise;
	logic sleep_report;
	logic sleep_report_ok;
	logic active;

	assign strobe_rise = serial_strobe_n && !strobe_q;
	assign strobe_fall = !serial_strobe_n && strobe_q;
	assign pin_rise    = sleep_reset_pin_n && !pin_q;
	assign active      = sleep_state == SLP_NORMAL;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_q    <= 1'b1;
			strobe_q <= 1'b1;
		end else begin
			pin_q    <= sleep_reset_pin_n;
			strobe_q <= serial_strobe_n;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			sleep_state     <= SLP_NORMAL;
			sleep_cnt       <= '0;
			sleep_report    <= 1'b0;
			sleep_report_ok <= 1'b0;
		end else begin
			unique case (sleep_state)
			SLP_NORMAL: begin
				sleep_cnt <= '0;
				if (!sleep_reset_pin_n) begin
					sleep_state <= SLP_ENTER_PIN; // see (R6)
				end else if (ctrl.sleep_request_bit && strobe_rise) begin
					sleep_state <= SLP_ENTER_BIT; // see (R7)
				end else if (wr_ctrl) begin
					sleep_report <= 1'b0;
				end
			end
			SLP_ENTER_PIN: begin
				if (sleep_reset_pin_n) begin
					// pulse too short: entry failed, still normal
					sleep_state     <= SLP_NORMAL;
					sleep_report    <= 1'b1;
					sleep_report_ok <= 1'b0; // see (R10)
				end else if (sleep_cnt == SLEEP_CYC - 1) begin
					sleep_state     <= SLP_ASLEEP_PIN;
					sleep_report    <= 1'b1;
					sleep_report_ok <= 1'b1; // see (R10)
				end else begin
					sleep_cnt <= sleep_cnt + 32'h1;
				end
			end
			SLP_ENTER_BIT: begin
				if (sleep_cnt == SLEEP_CYC - 1) begin
					sleep_state     <= SLP_ASLEEP_BIT; // see (R7)
					sleep_report    <= 1'b1;
					sleep_report_ok <= 1'b1;
				end else begin
					sleep_cnt <= sleep_cnt + 32'h1;
				end
			end
			SLP_ASLEEP_PIN: begin
				sleep_cnt <= '0;
				if (pin_rise) begin
					sleep_state <= SLP_WAKING; // see (R12)
				end
			end
			SLP_ASLEEP_BIT: begin
				sleep_cnt <= '0;
				if (strobe_fall) begin
					sleep_state <= SLP_WAKE_XFER; // see (R13)
				end
			end
			SLP_WAKE_XFER: begin
				// host keeps lines quiet for the ready time, see (R15)
				if (strobe_rise) begin
					if (!ctrl.sleep_request_bit && sleep_reset_pin_n) begin
						sleep_state <= SLP_WAKING; // see (R14)
					end else begin
						sleep_state     <= SLP_ASLEEP_BIT; // see (R14)
						sleep_report    <= 1'b1;
						sleep_report_ok <= 1'b0;
					end
				end
			end
			SLP_WAKING: begin
				if (sleep_cnt == WAKE_CYC - 1) begin
					sleep_cnt <= '0;
					sleep_report    <= 1'b1;
					// pin low or bit set still means sleep, see (R8)
					if (sleep_reset_pin_n && !ctrl.sleep_request_bit) begin
						sleep_state     <= SLP_NORMAL;
						sleep_report_ok <= 1'b1;
					end else begin
						sleep_state     <= sleep_reset_pin_n ? SLP_ASLEEP_BIT : SLP_ASLEEP_PIN;
						sleep_report_ok <= 1'b0;
					end
				end else begin
					sleep_cnt <= sleep_cnt + 32'h1;
				end
			end
			default: begin
				sleep_state <= SLP_NORMAL;
			end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// fault states and sticky status
	// ----------------------------------------------------------------
	logic [1:0] short_latched;
	logic open_latched;
	logic static_any;
	logic dynamic_any;
	logic supply_err;
	logic hard_static;
	dsf_pkg::dsf_fault_s fault_now;

	assign supply_err  = fault_in.supply_overvolt || fault_in.supply_undervolt
		|| fault_in.cp_undervolt; // see (R23)
	assign hard_static = supply_err || fault_in.overtemp; // see (R18)
	assign static_any  = hard_static || fault_in.temp_warning || fault_in.serial_fault;
	assign dynamic_any = |short_latched || open_latched;

	always_comb begin
		fault_now              = fault_in;
		fault_now.bridge_short = (|short_latched && !wr_status) || fault_in.bridge_short;
		fault_now.bridge_open  = (open_latched && !wr_status) || fault_in.bridge_open;
	end

	// dynamic states hold until the status register is reset
	always_ff @(posedge core_clk) begin
		if (rst) begin
			short_latched <= 2'h0;
			open_latched  <= 1'b0;
		end else begin
			short_latched <= (wr_status ? 2'h0 : short_latched)
				| (fault_in.bridge_short ? short_phase : 2'h0); // see (R17)
			open_latched  <= (!wr_status && open_latched) || fault_in.bridge_open; // see (R17)
		end
	end

	// set wins over the reset write, so a live fault re-flags at once
	always_ff @(posedge core_clk) begin
		if (rst) begin
			status <= '0;
		end else begin
			status <= (wr_status ? '0 : status) | fault_now; // see (R19) see (R20)
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
			dsf_pkg::ADDR_CTRL:   prdata <= 32'(ctrl);
			dsf_pkg::ADDR_STATUS: prdata <= 32'(status);
			dsf_pkg::ADDR_STATE:  prdata <= {13'h0, sleep_state, pwm_period_cyc};
			default:              prdata <= 32'h0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// pwm period and dither
	// ----------------------------------------------------------------
	logic [15:0] base_cyc;
	logic [15:0] step_cyc;
	logic [15:0] shorten;
	logic [15:0] target_cyc;
	logic [15:0] pwm_cnt;
	logic [3:0]  level;
	logic        going_down;
	logic [31:0] dwell_cnt;
	logic [31:0] dwell_len;
	logic        dwell_done;
	logic        dither_on;

	assign base_cyc = 16'(dsf_pkg::BASE_PERIOD_CYC)
		+ 16'(ctrl.base_period_code) * 16'(dsf_pkg::BASE_STEP_CYC); // see (R24)
	assign step_cyc = 16'(dsf_pkg::DITHER_UNIT_CYC)
		+ 16'(ctrl.dither_step_code) * 16'(dsf_pkg::DITHER_UNIT_CYC); // see (R2)
	assign shorten  = 16'(level) * step_cyc;
	assign dither_on = ctrl.dither_step_count != 4'h0; // see (R4)

	always_comb begin
		if (!dither_on || shorten >= base_cyc) begin
			target_cyc = dither_on ? 16'(dsf_pkg::MIN_PERIOD_CYC) : base_cyc;
		end else if (base_cyc - shorten < 16'(dsf_pkg::MIN_PERIOD_CYC)) begin
			target_cyc = 16'(dsf_pkg::MIN_PERIOD_CYC); // see (R5)
		end else begin
			target_cyc = base_cyc - shorten;
		end
	end

	always_comb begin
		unique case (ctrl.dither_dwell_code)
		2'h0: dwell_len = 32'(DWELL_1_CYC); // see (R3)
		2'h1: dwell_len = 32'(DWELL_2_CYC);
		2'h2: dwell_len = 32'(DWELL_5_CYC);
		2'h3: dwell_len = 32'(DWELL_10_CYC);
		endcase
	end

	assign dwell_done = dwell_cnt >= dwell_len - 32'h1;

	always_ff @(posedge core_clk) begin
		if (rst || !dither_on || !active) begin
			dwell_cnt  <= '0;
			level      <= 4'h0;
			going_down <= 1'b1;
		end else if (dwell_done) begin
			dwell_cnt <= '0; // see (R26)
			if (going_down) begin
				level <= level + 4'h1; // see (R1)
				if (level + 4'h1 >= ctrl.dither_step_count) begin
					going_down <= 1'b0;
				end
			end else begin
				level <= level - 4'h1; // see (R1)
				if (level <= 4'h1) begin
					going_down <= 1'b1;
				end
			end
		end else begin
			dwell_cnt <= dwell_cnt + 32'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			pwm_cnt          <= '0;
			pwm_period_cyc   <= 16'(dsf_pkg::BASE_PERIOD_CYC);
			pwm_period_start <= 1'b0;
		end else if (pwm_cnt >= pwm_period_cyc - 16'h1) begin
			pwm_cnt          <= '0;
			pwm_period_cyc   <= target_cyc; // see (R25)
			pwm_period_start <= 1'b1;
		end else begin
			pwm_cnt          <= pwm_cnt + 16'h1;
			pwm_period_start <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// outputs and indicator
	// ----------------------------------------------------------------
	logic [31:0] div_cnt;
	logic        div_clk;
	logic        ind_level;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			div_cnt <= '0;
			div_clk <= 1'b0;
		end else if (div_cnt == 32'(IND_HALF - 1)) begin
			div_cnt <= '0;
			div_clk <= !div_clk; // see (R22)
		end else begin
			div_cnt <= div_cnt + 32'h1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			ind_level <= 1'b1;
		end else if (sleep_report) begin
			ind_level <= sleep_report_ok; // see (R10)
		end else begin
			unique case (ctrl.indicator_select)
			dsf_pkg::IND_GENERAL:      ind_level <= !(static_any || dynamic_any); // see (R21)
			dsf_pkg::IND_SUPPLY:       ind_level <= !supply_err; // see (R23)
			dsf_pkg::IND_OPEN_LOAD:    ind_level <= !open_latched; // see (R22)
			dsf_pkg::IND_PHASE_A_PWM:  ind_level <= phase_a_pwm;
			dsf_pkg::IND_STEP:         ind_level <= step_pulse;
			dsf_pkg::IND_SEQ_ACTIVE_N: ind_level <= !sequence_active_flag;
			dsf_pkg::IND_DIV_CLK:      ind_level <= div_clk;
			dsf_pkg::IND_SPARE:        ind_level <= !(static_any || dynamic_any);
			endcase
		end
	end

	// open drain: only ever pulls low
	assign fault_indicator_pin_o  = 1'b0;
	assign fault_indicator_pin_oe = !ind_level;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			bridge_enable    <= 2'h0;
			regulator_enable <= 1'b1;
		end else begin
			regulator_enable <= sleep_state == SLP_NORMAL || sleep_state == SLP_WAKING
				|| sleep_state == SLP_WAKE_XFER || sleep_state == SLP_ENTER_PIN
				|| sleep_state == SLP_ENTER_BIT; // see (R9)
			bridge_enable    <= (active && !hard_static) ? ~short_latched : 2'h0; // see (R9) see (R18)
		end
	end

endmodule

// ===== hw/dsf_pkg.sv
/*
 * dsf_pkg: constants, register map and carrier types for the dither, sleep
 * and fault control block.
 * Assumes a single 100 MHz core clock; every count is derived from it here.
 */
package dsf_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ           = 100;
	localparam int BASE_PERIOD_NS    = 36000;
	localparam int BASE_STEP_NS      = 800;
	localparam int DITHER_UNIT_NS    = 200;
	localparam int MIN_PERIOD_NS     = 18000;
	localparam int DWELL_1_MS        = 1;
	localparam int DWELL_2_MS        = 2;
	localparam int DWELL_5_MS        = 5;
	localparam int DWELL_10_MS       = 10;
	localparam int SLEEP_ENTRY_US    = 30;
	localparam int WAKE_TIME_US      = 100;
	localparam real INDICATOR_CLK_HZ = 78.125;

	localparam int BASE_PERIOD_CYC = BASE_PERIOD_NS * CLK_MHZ / 1000;
	localparam int BASE_STEP_CYC   = BASE_STEP_NS * CLK_MHZ / 1000;
	localparam int DITHER_UNIT_CYC = DITHER_UNIT_NS * CLK_MHZ / 1000;
	localparam int MIN_PERIOD_CYC  = (MIN_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int MS_CYC          = 1000 * CLK_MHZ;
	localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_US * CLK_MHZ;
	localparam int WAKE_TIME_CYC   = WAKE_TIME_US * CLK_MHZ;
	// half period of the divided indicator clock
	localparam int IND_HALF_CYC    = int'(CLK_MHZ * 1.0e6 / INDICATOR_CLK_HZ / 2.0);

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_STATE  = 8'h08;

	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		IND_GENERAL, IND_SUPPLY, IND_OPEN_LOAD, IND_PHASE_A_PWM,
		IND_STEP, IND_SEQ_ACTIVE_N, IND_DIV_CLK, IND_SPARE
	} dsf_ind_e;

	typedef struct packed {
		logic           sleep_request_bit;
		dsf_ind_e       indicator_select;
		logic [3:0]     dither_step_count;
		logic [1:0]     dither_dwell_code;
		logic [2:0]     dither_step_code;
		logic [4:0]     base_period_code;
	} dsf_ctrl_s;

	// static conditions and dynamic events, one bit each
	typedef struct packed {
		logic bridge_open;
		logic bridge_short;
		logic serial_fault;
		logic overtemp;
		logic temp_warning;
		logic cp_undervolt;
		logic supply_undervolt;
		logic supply_overvolt;
	} dsf_fault_s;

endpackage
